// ==== sds_pkg.sv ====
// Shared constants and types for the status-read and sleep-entry command block
package sds_pkg;

    // ************************************************************
    // Command codes
    // ************************************************************
    localparam logic [7:0] SDS_CMD_RD_SIG = 8'h0E;
    localparam logic [7:0] SDS_CMD_RD_DIAG = 8'h0F;
    localparam logic [7:0] SDS_CMD_SLEEP_IN = 8'h10;
    localparam logic [7:0] SDS_CMD_SLEEP_OUT = 8'h11;

    // ************************************************************
    // Status byte layouts and reset values
    // ************************************************************
    localparam int SDS_SIG_TE_ON = 7;
    localparam int SDS_SIG_TE_MODE = 6;
    localparam int SDS_SIG_HS_ON = 5;
    localparam int SDS_SIG_VS_ON = 4;
    localparam int SDS_SIG_PCLK_ON = 3;
    localparam int SDS_SIG_DE_ON = 2;
    localparam int SDS_SIG_DSI_ERR = 0;
    localparam int SDS_DIAG_LOAD = 7;
    localparam int SDS_DIAG_FUNC = 6;
    localparam int SDS_DIAG_CSUM = 0;
    localparam logic [7:0] SDS_DIAG_MASK = 8'hC1;
    localparam logic [7:0] SDS_SIG_RST = 8'h00;
    localparam logic [7:0] SDS_DIAG_RST = 8'h00;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int SDS_CLK_HZ = 40_000_000;
    localparam int SDS_SETTLE_MS = 5;
    localparam int SDS_WAKE_HOLD_MS = 120;
    localparam int SDS_CSUM_WAIT_MS = 300;
    localparam int SDS_SETTLE_CYC = SDS_SETTLE_MS * (SDS_CLK_HZ / 1000);
    localparam int SDS_WAKE_HOLD_CYC = SDS_WAKE_HOLD_MS * (SDS_CLK_HZ / 1000);
    localparam int SDS_CSUM_WAIT_CYC = SDS_CSUM_WAIT_MS * (SDS_CLK_HZ / 1000);
    localparam int SDS_CNT_W = 24;
    localparam int SDS_STEP_W = 4;
    localparam logic [3:0] SDS_STEP_CYC = 4'h4;
    localparam logic [1:0] SDS_PAR_MAX = 2'h2;

    // ************************************************************
    // State encodings
    // ************************************************************
    typedef enum logic [5:0] {
        SDS_DS_AWAKE = 6'b000001,
        SDS_DS_BLANK = 6'b000010,
        SDS_DS_DISCH = 6'b000100,
        SDS_DS_DCDC_OFF = 6'b001000,
        SDS_DS_OSC_OFF = 6'b010000,
        SDS_DS_ASLEEP = 6'b100000
    } sds_dev_st_t;

    typedef enum logic [3:0] {
        SDS_HS_IDLE = 4'b0001,
        SDS_HS_CMD = 4'b0010,
        SDS_HS_RD = 4'b0100,
        SDS_HS_GET = 4'b1000
    } sds_host_st_t;

endpackage

// ==== sds_bus_if.sv ====
// Parallel command bus joining the display driver and its host
`timescale 1ns/1ps
interface sds_bus_if;
    logic command_data_select;
    logic write_strobe;
    logic read_strobe;
    logic dsi_mode;
    logic [7:0] host_data;
    logic [7:0] dev_data;
    logic dev_data_oe;

    modport host (
        output command_data_select, write_strobe, read_strobe, dsi_mode, host_data,
        input dev_data, dev_data_oe
    );
    modport device (
        input command_data_select, write_strobe, read_strobe, dsi_mode, host_data,
        output dev_data, dev_data_oe
    );
endinterface

// ==== sds_device.sv ====
// Display driver end: status reads, sleep entry and wake handling
//
// Overview of operation
// - Extra parallel reads repeat the second parameter
// - DSI reads return status byte only
// - First byte dummy, second byte is status
// - Code 0Fh reads diagnostics, bits 5-1 zero
// - Bit 7 toggles on good register load
// - Bit 6 toggles on good functionality check
// - Bit 0 flags checksum mismatch
// - Host waits 300ms before trusting bit 0
// - Diagnostics refresh only on a wake command received while asleep
// - Code 10h, no parameters, enters sleep
// - Sleep stops converter, oscillator, panel scanning
// - Host interface and memory keep working asleep
// - No dimming on entry into sleep
// - Sleep entry while asleep does nothing
// - Only code 11h ends sleep; here sw_rst or sys_rst also ends it, loading the awake defaults
// - Host waits 5ms after sleep entry
// - Host waits 120ms after wake before sleep
// - Blank, discharge, converter off, oscillator off, sleep
// - Auto blank leaves display on setting alone
// - Signal status bit order as listed
// - Wake restarts converter, oscillator, scanning
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module sds_device
    import sds_pkg::*;
(
    input wire logic clk_sys, // System clock, 40 MHz
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic sw_rst, // Software reset, one-cycle pulse
    sds_bus_if.device bus, // Command bus toward the host
    input wire logic te_on, // Tearing output enabled
    input wire logic te_mode, // Tearing output mode 2
    input wire logic hsync_on, // Horizontal sync active
    input wire logic vsync_on, // Vertical sync active
    input wire logic pixel_clock_pin_on, // Pixel clock active
    input wire logic data_enable_on, // Data enable active
    input wire logic link_err, // Link error seen, pulse
    input wire logic reg_load_ok, // Register load finished correctly
    input wire logic func_ok, // Functionality check passed
    input wire logic csum_mismatch, // Checksums differ
    input wire logic disp_on_setting, // Stored display on/off setting
    output logic dcdc_en, // Converter running
    output logic osc_en, // Internal oscillator running
    output logic scan_en, // Panel scanning running
    output logic blank_screen, // Automatic blank screen shown
    output logic panel_discharge, // Panel charge being drained
    output logic dim_allow, // Dimming transition permitted
    output logic panel_show, // Memory contents shown on panel
    output logic asleep // Sleep state reached
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        sds_dev_st_t st;
        logic [7:0] cmd;
        logic [1:0] par;
        logic [7:0] dout;
        logic doe;
        logic [7:0] diag;
        logic dsi_err;
        logic [SDS_STEP_W-1:0] step;
        logic dcdc;
        logic osc;
        logic scan;
        logic blank;
        logic disch;
        logic dim_ok;
        logic show;
        logic slp;
    } sds_dev_s_t;

    localparam sds_dev_s_t RST_VAL = '{
        st: SDS_DS_AWAKE,
        cmd: 8'h00,
        par: 2'h0,
        dout: 8'h00,
        doe: 1'b0,
        diag: SDS_DIAG_RST,
        dsi_err: 1'b0,
        step: 4'h0,
        dcdc: 1'b1,
        osc: 1'b1,
        scan: 1'b1,
        blank: 1'b0,
        disch: 1'b0,
        dim_ok: 1'b1,
        show: 1'b0,
        slp: 1'b0
    };

    sds_dev_s_t s_q;
    sds_dev_s_t s_d;
    logic [7:0] sig_byte;

    always_comb begin
        sig_byte = SDS_SIG_RST;
        sig_byte[SDS_SIG_TE_ON] = te_on;
        sig_byte[SDS_SIG_TE_MODE] = te_mode;
        sig_byte[SDS_SIG_HS_ON] = hsync_on;
        sig_byte[SDS_SIG_VS_ON] = vsync_on;
        sig_byte[SDS_SIG_PCLK_ON] = pixel_clock_pin_on;
        sig_byte[SDS_SIG_DE_ON] = data_enable_on;
        sig_byte[SDS_SIG_DSI_ERR] = s_q.dsi_err;
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.doe = 1'b0;
        if (link_err) begin
            s_d.dsi_err = 1'b1;
        end
        // interface decodes in every power state
        if (bus.write_strobe && !bus.command_data_select) begin
            s_d.cmd = bus.host_data;
            s_d.par = 2'h0;
            if (bus.host_data == SDS_CMD_SLEEP_IN && s_q.st == SDS_DS_AWAKE) begin
                s_d.st = SDS_DS_BLANK;
                s_d.step = 4'h0;
                // blank without touching the display setting
                s_d.blank = 1'b1;
                s_d.dim_ok = 1'b0;
            end
            // wake only on code 11h from sleep
            if (bus.host_data == SDS_CMD_SLEEP_OUT && s_q.st == SDS_DS_ASLEEP) begin
                s_d.st = SDS_DS_AWAKE;
                s_d.osc = 1'b1;
                s_d.dcdc = 1'b1;
                s_d.scan = 1'b1;
                s_d.blank = 1'b0;
                s_d.dim_ok = 1'b1;
                s_d.slp = 1'b0;
                s_d.diag[SDS_DIAG_LOAD] = s_q.diag[SDS_DIAG_LOAD] ^ reg_load_ok;
                s_d.diag[SDS_DIAG_FUNC] = s_q.diag[SDS_DIAG_FUNC] ^ func_ok;
                s_d.diag[SDS_DIAG_CSUM] = csum_mismatch;
            end
        end
        if (bus.read_strobe && bus.command_data_select) begin
            if (s_q.cmd == SDS_CMD_RD_SIG || s_q.cmd == SDS_CMD_RD_DIAG) begin
                // dummy only on the parallel bus
                if (bus.dsi_mode || s_q.par != 2'h0) begin
                    s_d.doe = 1'b1;
                    // diag bits 5 to 1 forced low
                    s_d.dout = (s_q.cmd == SDS_CMD_RD_SIG) ? sig_byte
                                                             : (s_q.diag & SDS_DIAG_MASK);
                end
                // count saturates so later reads repeat
                if (s_q.par != SDS_PAR_MAX) begin
                    s_d.par = s_q.par + 2'h1;
                end
            end
        end
        if (s_q.st != SDS_DS_AWAKE && s_q.st != SDS_DS_ASLEEP) begin
            s_d.step = s_q.step + 4'h1;
            if (s_q.step == SDS_STEP_CYC - 4'h1) begin
                s_d.step = 4'h0;
                case (s_q.st)
                    SDS_DS_BLANK: begin
                        s_d.st = SDS_DS_DISCH;
                        s_d.scan = 1'b0;
                        s_d.disch = 1'b1;
                    end
                    SDS_DS_DISCH: begin
                        s_d.st = SDS_DS_DCDC_OFF;
                        s_d.disch = 1'b0;
                        s_d.dcdc = 1'b0;
                    end
                    SDS_DS_DCDC_OFF: begin
                        s_d.st = SDS_DS_OSC_OFF;
                        s_d.osc = 1'b0;
                    end
                    SDS_DS_OSC_OFF: begin
                        s_d.st = SDS_DS_ASLEEP;
                        s_d.slp = 1'b1;
                    end
                    default: begin
                        s_d.st = SDS_DS_AWAKE;
                    end
                endcase
            end
        end
        s_d.show = disp_on_setting && s_d.scan && !s_d.blank;
        // Soft reset reloads every default, link error included
        if (sw_rst) begin
            s_d = RST_VAL;
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= RST_VAL;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.dev_data = s_q.dout;
    assign bus.dev_data_oe = s_q.doe;
    assign dcdc_en = s_q.dcdc;
    assign osc_en = s_q.osc;
    assign scan_en = s_q.scan;
    assign blank_screen = s_q.blank;
    assign panel_discharge = s_q.disch;
    assign dim_allow = s_q.dim_ok;
    assign panel_show = s_q.show;
    assign asleep = s_q.slp;

endmodule // sds_device

// ==== sds_host.sv ====
// Host end: issues commands, reads status and keeps the wait times
`timescale 1ns/1ps
module sds_host
    import sds_pkg::*;
#(
    parameter int SETTLE_CYC = SDS_SETTLE_CYC,
    parameter int WAKE_HOLD_CYC = SDS_WAKE_HOLD_CYC,
    parameter int CSUM_WAIT_CYC = SDS_CSUM_WAIT_CYC
) (
    input wire logic clk_sys, // System clock, 40 MHz
    input wire logic sys_rst, // Asynchronous reset, active high
    sds_bus_if.host bus, // Command bus toward the driver
    input wire logic dsi_sel, // Read as over DSI: one byte only
    input wire logic req, // Command request, one-cycle pulse
    input wire logic [7:0] req_cmd, // Command code
    input wire logic req_rd, // Command reads one status byte back
    output logic busy, // Request would be refused now
    output logic sleep_hold, // Sleep entry still barred after wake
    output logic done, // Command finished, one-cycle pulse
    output logic [7:0] rdata, // Status byte of the last read
    output logic csum_ready // Checksum bit may be trusted
);

    typedef struct packed {
        sds_host_st_t st;
        logic rd;
        logic wr;
        logic cds;
        logic dsi;
        logic [7:0] hd;
        logic left;
        logic [SDS_CNT_W-1:0] gap;
        logic [SDS_CNT_W-1:0] hold;
        logic [SDS_CNT_W-1:0] csum;
        logic busy;
        logic done;
        logic [7:0] rdata;
    } sds_host_s_t;

    sds_host_s_t s_q;
    sds_host_s_t s_d;
    logic take;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        s_d.wr = 1'b0;
        s_d.rd = 1'b0;
        s_d.dsi = dsi_sel;
        if (s_q.gap != '0) s_d.gap = s_q.gap - 1'b1;
        if (s_q.hold != '0) s_d.hold = s_q.hold - 1'b1;
        if (s_q.csum != '0) s_d.csum = s_q.csum - 1'b1;
        // no sleep entry while the wake hold runs
        take = req && s_q.st == SDS_HS_IDLE && s_q.gap == '0
            && !(req_cmd == SDS_CMD_SLEEP_IN && s_q.hold != '0);
        case (s_q.st)
            SDS_HS_IDLE: begin
                if (take) begin
                    s_d.st = SDS_HS_CMD;
                    s_d.wr = 1'b1;
                    s_d.cds = 1'b0;
                    s_d.hd = req_cmd;
                    // parallel reads need a discarded dummy first
                    s_d.left = req_rd && !dsi_sel;
                    if (req_cmd == SDS_CMD_SLEEP_IN || req_cmd == SDS_CMD_SLEEP_OUT) begin
                        s_d.gap = SDS_CNT_W'(SETTLE_CYC);
                    end
                    if (req_cmd == SDS_CMD_SLEEP_OUT) begin
                        s_d.hold = SDS_CNT_W'(WAKE_HOLD_CYC);
                    end
                    // checksum bit settles after register writes
                    if (!req_rd) begin
                        s_d.csum = SDS_CNT_W'(CSUM_WAIT_CYC);
                    end
                    if (req_rd) begin
                        s_d.st = SDS_HS_CMD;
                    end
                end
            end
            SDS_HS_CMD: begin
                if (s_q.left || s_q.hd == SDS_CMD_RD_SIG || s_q.hd == SDS_CMD_RD_DIAG) begin
                    s_d.st = SDS_HS_RD;
                    s_d.rd = 1'b1;
                    s_d.cds = 1'b1;
                end else begin
                    s_d.st = SDS_HS_IDLE;
                    s_d.done = 1'b1;
                end
            end
            SDS_HS_RD: begin
                s_d.st = SDS_HS_GET;
            end
            SDS_HS_GET: begin
                if (s_q.left) begin
                    s_d.left = 1'b0;
                    s_d.rd = 1'b1;
                    s_d.st = SDS_HS_RD;
                end else begin
                    s_d.rdata = bus.dev_data;
                    s_d.done = 1'b1;
                    s_d.st = SDS_HS_IDLE;
                end
            end
            default: begin
                s_d.st = SDS_HS_IDLE;
            end
        endcase
        s_d.busy = s_d.st != SDS_HS_IDLE || s_d.gap != '0;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '{st: SDS_HS_IDLE, cds: 1'b1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign bus.command_data_select = s_q.cds;
    assign bus.write_strobe = s_q.wr;
    assign bus.read_strobe = s_q.rd;
    assign bus.dsi_mode = s_q.dsi;
    assign bus.host_data = s_q.hd;
    assign busy = s_q.busy;
    assign sleep_hold = s_q.hold != '0;
    assign done = s_q.done;
    assign rdata = s_q.rdata;
    assign csum_ready = s_q.csum == '0;

endmodule // sds_host

// ==== sds_props.sv ====
// Interface checker for the status-read and sleep-entry command bus
`timescale 1ns/1ps
module sds_props
    import sds_pkg::*;
#(
    parameter int SETTLE_CYC = SDS_SETTLE_CYC,
    parameter int WAKE_HOLD_CYC = SDS_WAKE_HOLD_CYC
) (
    input wire logic clk_sys, // System clock
    input wire logic sys_rst, // Reset, active high
    input wire logic command_data_select, // Command or parameter
    input wire logic write_strobe, // Command write
    input wire logic read_strobe, // Parameter read
    input wire logic dsi_mode, // DSI-style reads
    input wire logic [7:0] host_data, // Command byte
    input wire logic [7:0] dev_data, // Status byte
    input wire logic dev_data_oe // Status byte driven
);
    logic [7:0] cmd_q;
    logic [1:0] rd_q;
    int gap_q;
    int wake_q;
    logic cmd_wr;
    logic rd_par;
    logic is_rd;
    assign cmd_wr = write_strobe && !command_data_select;
    assign rd_par = read_strobe && command_data_select;
    assign is_rd = (cmd_q == SDS_CMD_RD_SIG) || (cmd_q == SDS_CMD_RD_DIAG);

    // ********
    // Command tracking
    // ********
    // Counters saturate so that reset looks like a long idle spell
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_q <= 8'h00;
            rd_q <= 2'h0;
            gap_q <= SETTLE_CYC;
            wake_q <= WAKE_HOLD_CYC;
        end else begin
            if (cmd_wr) begin
                cmd_q <= host_data;
                rd_q <= 2'h0;
            end else if (rd_par && rd_q != 2'h3) begin
                rd_q <= rd_q + 2'h1;
            end
            if (cmd_wr && (host_data == SDS_CMD_SLEEP_IN || host_data == SDS_CMD_SLEEP_OUT)) begin
                gap_q <= 0;
            end else if (gap_q < SETTLE_CYC) begin
                gap_q <= gap_q + 1;
            end
            if (cmd_wr && host_data == SDS_CMD_SLEEP_OUT) begin
                wake_q <= 0;
            end else if (wake_q < WAKE_HOLD_CYC) begin
                wake_q <= wake_q + 1;
            end
        end
    end

    // ********
    // Properties
    // ********
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    dummy_quiet_a: assert property (rd_par && !dsi_mode && rd_q == 2'h0 |=> !dev_data_oe)
        else $error("dummy read drove the bus");
    second_byte_a: assert property (rd_par && !dsi_mode && rd_q == 2'h1 && is_rd |=> dev_data_oe)
        else $error("second read returned nothing");
    dsi_status_a: assert property (rd_par && dsi_mode && is_rd |=> dev_data_oe)
        else $error("DSI read returned nothing");
    oe_cause_a: assert property (dev_data_oe |-> $past(rd_par) && is_rd)
        else $error("status byte without a read");
    diag_zero_a: assert property (dev_data_oe && cmd_q == SDS_CMD_RD_DIAG |-> dev_data[5:1] == 5'h00)
        else $error("unused diagnostic bits set");
    rd_follow_a: assert property (cmd_wr && (host_data == SDS_CMD_RD_SIG ||
        host_data == SDS_CMD_RD_DIAG) |=> rd_par)
        else $error("status read not started");
    settle_gap_a: assert property (cmd_wr |-> gap_q + 1 >= SETTLE_CYC)
        else $error("command too soon after power change");
    wake_gap_a: assert property (cmd_wr && host_data == SDS_CMD_SLEEP_IN |-> wake_q + 1 >= WAKE_HOLD_CYC)
        else $error("sleep entry too soon after wake");

    cover property (rd_par && dsi_mode && is_rd);
    cover property (dev_data_oe && cmd_q == SDS_CMD_RD_DIAG);
    cover property (cmd_wr && host_data == SDS_CMD_SLEEP_IN);
    cover property (cmd_wr && host_data == SDS_CMD_SLEEP_OUT);
endmodule // sds_props

// ==== tb_top.sv ====
// Self-checking bench joining the host and driver ends of the command bus
`timescale 1ns/1ps
module tb_top;
    import sds_pkg::*;
    localparam int SETTLE = 20;
    localparam int HOLD = 50;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic sw_rst = 1'b0;
    logic [5:0] sig_in = 6'h00;
    logic link_err = 1'b0;
    logic [2:0] diag_in = 3'h0;
    logic dsi_sel = 1'b0;
    logic req = 1'b0;
    logic [7:0] req_cmd = 8'h00;
    logic req_rd = 1'b0;
    logic disp_on = 1'b1;
    logic busy, sleep_hold, done, csum_ready;
    logic [7:0] rdata;
    logic dcdc_en, osc_en, scan_en, blank_screen, panel_discharge, dim_allow, panel_show, asleep;
    logic exp_err = 1'b0;
    logic [7:0] diag_q = SDS_DIAG_RST;
    int n_errors = 0;
    int compares = 0;

    sds_bus_if bus_if ();
    sds_device sds_device_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .sw_rst(sw_rst),
        .bus(bus_if), .te_on(sig_in[5]), .te_mode(sig_in[4]), .hsync_on(sig_in[3]),
        .vsync_on(sig_in[2]), .pixel_clock_pin_on(sig_in[1]), .data_enable_on(sig_in[0]),
        .link_err(link_err), .reg_load_ok(diag_in[2]), .func_ok(diag_in[1]),
        .csum_mismatch(diag_in[0]), .disp_on_setting(disp_on), .dcdc_en(dcdc_en),
        .osc_en(osc_en), .scan_en(scan_en), .blank_screen(blank_screen),
        .panel_discharge(panel_discharge), .dim_allow(dim_allow), .panel_show(panel_show),
        .asleep(asleep));
    sds_host #(.SETTLE_CYC(SETTLE), .WAKE_HOLD_CYC(HOLD), .CSUM_WAIT_CYC(30)) sds_host_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .bus(bus_if), .dsi_sel(dsi_sel), .req(req),
        .req_cmd(req_cmd), .req_rd(req_rd), .busy(busy), .sleep_hold(sleep_hold),
        .done(done), .rdata(rdata), .csum_ready(csum_ready));
    sds_props #(.SETTLE_CYC(SETTLE), .WAKE_HOLD_CYC(HOLD)) sds_props_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst),
        .command_data_select(bus_if.command_data_select),
        .write_strobe(bus_if.write_strobe), .read_strobe(bus_if.read_strobe),
        .dsi_mode(bus_if.dsi_mode), .host_data(bus_if.host_data),
        .dev_data(bus_if.dev_data), .dev_data_oe(bus_if.dev_data_oe));

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // ********
    // Helpers
    // ********
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Power outputs {scan, discharge, converter, oscillator, asleep} k cycles into entry
    function automatic logic [4:0] exp_pwr(input int k);
        if (k < 4) return 5'h16;
        if (k < 8) return 5'h0E;
        if (k < 12) return 5'h02;
        if (k < 16) return 5'h00;
        return 5'h01;
    endfunction

    task automatic issue(input logic [7:0] cmd, input logic rd, input logic hold);
        #1;
        for (int i = 0; i < 400 && (busy !== 1'b0 || (hold && sleep_hold !== 1'b0)); i++) begin
            @(posedge clk_sys);
            #1;
        end
        @(posedge clk_sys);
        req <= 1'b1;
        req_cmd <= cmd;
        req_rd <= rd;
        @(posedge clk_sys);
        req <= 1'b0;
    endtask

    task automatic run(input logic [7:0] cmd, input logic rd, input logic ok);
        logic seen;
        seen = 1'b0;
        issue(cmd, rd, ok);
        for (int i = 0; i < 10; i++) begin
            #1;
            if (done === 1'b1) seen = 1'b1;
            @(posedge clk_sys);
        end
        check({7'h00, seen}, {7'h00, ok});
    endtask

    task automatic sleep_seq();
        int k;
        k = -1;
        issue(SDS_CMD_SLEEP_IN, 1'b0, 1'b1);
        for (int i = 0; i < 30; i++) begin
            #1;
            if (k < 0 && blank_screen === 1'b1) begin
                k = 0;
                check({6'h00, dim_allow, panel_show}, 8'h00);
            end
            if (k >= 0 && k <= 16) begin
                check({3'h0, scan_en, panel_discharge, dcdc_en, osc_en, asleep}, {3'h0, exp_pwr(k)});
                k++;
            end
            @(posedge clk_sys);
        end
        check({7'h00, asleep}, 8'h01);
    endtask

    task automatic chk_rst();
        check({dcdc_en, osc_en, scan_en, dim_allow, blank_screen, panel_discharge, asleep, csum_ready}, 8'hF1);
    endtask

    // ********
    // Main sequence
    // ********
    initial begin
        void'($urandom(32'h3B283EC9));
        repeat (6) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        chk_rst();
        @(posedge clk_sys);
        // Random status reads, both read styles, link error raised before the ninth read
        for (int n = 0; n < 24; n++) begin
            sig_in <= 6'($urandom);
            dsi_sel <= 1'($urandom);
            link_err <= (n == 8);
            @(posedge clk_sys);
            link_err <= 1'b0;
            if (n == 8) exp_err = 1'b1;
            run((n % 2) ? SDS_CMD_RD_DIAG : SDS_CMD_RD_SIG, 1'b1, 1'b1);
            check(rdata, (n % 2) ? diag_q : {sig_in, 1'b0, exp_err});
        end
        for (int r = 0; r < 2; r++) begin
            sleep_seq();
            run(SDS_CMD_RD_SIG, 1'b1, 1'b1);
            check(rdata, {sig_in, 1'b0, exp_err});
            run(SDS_CMD_SLEEP_IN, 1'b0, 1'b1);
            run(8'h13, 1'b0, 1'b1);
            check({4'h0, asleep, osc_en, dcdc_en, scan_en}, 8'h08);
            {disp_on, diag_in} <= 4'($urandom);
            run(SDS_CMD_SLEEP_OUT, 1'b0, 1'b1);
            diag_q = {diag_q[7] ^ diag_in[2], diag_q[6] ^ diag_in[1], 5'h00, diag_in[0]};
            check({2'h0, asleep, osc_en, dcdc_en, scan_en, dim_allow, blank_screen}, 8'h1E);
            check({5'h00, busy, sleep_hold, csum_ready}, 8'h06);
            check({7'h00, panel_show}, {7'h00, disp_on});
            run(SDS_CMD_SLEEP_IN, 1'b0, 1'b0);
            check({6'h00, asleep, blank_screen}, 8'h00);
            run(SDS_CMD_RD_DIAG, 1'b1, 1'b1);
            check(rdata, diag_q);
            repeat (40) @(posedge clk_sys);
            check({7'h00, csum_ready}, 8'h01);
        end
        sw_rst <= 1'b1;
        @(posedge clk_sys);
        sw_rst <= 1'b0;
        exp_err = 1'b0;
        run(SDS_CMD_RD_SIG, 1'b1, 1'b1);
        check(rdata, {sig_in, 2'h0});
        run(SDS_CMD_RD_DIAG, 1'b1, 1'b1);
        check(rdata, SDS_DIAG_RST);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1;
        chk_rst();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        wrap_up();
    end
endmodule // tb_top
